/* File: rssr_pkg.sv */
// Package: constants and types for the remote status and service-request block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package rssr_pkg;

   // ------------------------------------------------------------
   // Status byte layout
   // ------------------------------------------------------------
   localparam int BIT_DATA_READY = 0;
   localparam int BIT_TRIG_OCC = 1;
   localparam int BIT_ERR_FAIL = 2;
   localparam int BIT_ZERO3 = 3;
   localparam int BIT_LOCAL = 4;
   localparam int BIT_POWER_ON = 5;
   localparam int BIT_SRQ_FLAG = 6;
   localparam int BIT_ZERO7 = 7;
   localparam int NUM_COND = 4;

   // ------------------------------------------------------------
   // Reset values and fixed answers
   // ------------------------------------------------------------
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic [7:0] STATUS_RESET = 8'h20;
   // Arbitrary class code for a measuring instrument
   localparam logic [7:0] ACCESSORY_CLASS = 8'h3c;
   localparam int ID_LEN = 7;
   localparam logic [2:0] PPOLL_LINE_RESET = 3'h0;

   // ------------------------------------------------------------
   // Interface command codes seen by the block
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      CMD_NONE = 5'h00,
      CMD_IFC = 5'h01,
      CMD_REN = 5'h02,
      CMD_NRE = 5'h03,
      CMD_MLA = 5'h04,
      CMD_MTA = 5'h05,
      CMD_UNL = 5'h06,
      CMD_UNT = 5'h07,
      CMD_GTL = 5'h08,
      CMD_LLO = 5'h09,
      CMD_SDC = 5'h0a,
      CMD_DCL = 5'h0b,
      CMD_GET = 5'h0c,
      CMD_SPE = 5'h0d,
      CMD_SPD = 5'h0e,
      CMD_SST = 5'h0f,
      CMD_PPE = 5'h10,
      CMD_PPD = 5'h11,
      CMD_PPU = 5'h12,
      CMD_SAI = 5'h13,
      CMD_SDI = 5'h14,
      CMD_SRQ = 5'h15,
      CMD_OTA = 5'h16
   } rssr_cmd_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_STATUS = 2'b01,
      TX_ACC = 2'b10,
      TX_ID = 2'b11
   } rssr_tx_t;
endpackage

/* File: rssr_remote_fsm.sv */
// Remote, local and lockout state plus talker and listener addressing.
// Assumes commands arrive as one-cycle strobes from an interface decoder.
`timescale 1ns/1ps
module rssr_remote_fsm (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic cmd_vld_i,
   input wire rssr_pkg::rssr_cmd_t cmd_i,
   input wire logic ren_line_i,
   output logic remote_o,
   output logic lockout_o,
   output logic listener_o,
   output logic talker_o
);
   typedef struct packed {
      logic ren_en;
      logic remote;
      logic lockout;
      logic listener;
      logic talker;
   } rssr_rem_state_t;

   rssr_rem_state_t state_q;
   rssr_rem_state_t state_d;

   always_comb
   begin
      state_d = state_q;
      if (!ren_line_i)
      begin
         state_d.ren_en = 1'b0;
      end
      if (cmd_vld_i)
      begin
         case (cmd_i)
            rssr_pkg::CMD_REN:
            begin
               state_d.ren_en = 1'b1;
            end
            rssr_pkg::CMD_NRE:
            begin
               state_d.ren_en = 1'b0;
               state_d.remote = 1'b0;
               state_d.lockout = 1'b0;
            end
            rssr_pkg::CMD_MLA:
            begin
               state_d.listener = 1'b1;
               if (state_q.ren_en)
               begin
                  state_d.remote = 1'b1;
               end
            end
            rssr_pkg::CMD_MTA:
            begin
               state_d.talker = 1'b1;
            end
            rssr_pkg::CMD_OTA:
            begin
               state_d.talker = 1'b0;
            end
            rssr_pkg::CMD_UNL:
            begin
               state_d.listener = 1'b0;
            end
            rssr_pkg::CMD_UNT:
            begin
               state_d.talker = 1'b0;
            end
            rssr_pkg::CMD_GTL:
            begin
               if (state_q.listener)
               begin
                  state_d.remote = 1'b0;
               end
            end
            rssr_pkg::CMD_LLO:
            begin
               state_d.lockout = 1'b1;
            end
            rssr_pkg::CMD_IFC:
            begin
               state_d.listener = 1'b0;
               state_d.talker = 1'b0;
            end
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign remote_o = state_q.remote;
   assign lockout_o = state_q.lockout;
   assign listener_o = state_q.listener;
   assign talker_o = state_q.talker;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_ifc_unaddress: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      cmd_vld_i && cmd_i == rssr_pkg::CMD_IFC |=> !listener_o && !talker_o)
      else $error("IFC did not drop addressing");
   a_nre_local: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      cmd_vld_i && cmd_i == rssr_pkg::CMD_NRE |=> !remote_o && !lockout_o)
      else $error("NRE did not return to local");
endmodule

/* File: rssr_tx_seq.sv */
// Talker byte sequencer for status, accessory and identity answers.
// Assumes the far side takes a byte in each cycle where tx_rdy_i is high.
`timescale 1ns/1ps
module rssr_tx_seq #(
   parameter int ID_LEN = rssr_pkg::ID_LEN
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire rssr_pkg::rssr_tx_t kind_i,
   input wire logic [7:0] status_i,
   input wire logic [8*ID_LEN-1:0] id_str_i,
   input wire logic tx_rdy_i,
   output logic tx_vld_o,
   output logic [7:0] tx_data_o,
   output logic tx_last_o
);
   typedef struct packed {
      rssr_pkg::rssr_tx_t kind;
      logic [3:0] idx;
      logic [7:0] data;
   } rssr_tx_state_t;

   rssr_tx_state_t state_q;
   rssr_tx_state_t state_d;
   logic last;

   always_comb
   begin
      state_d = state_q;
      last = (state_q.kind != rssr_pkg::TX_ID) || (state_q.idx == 4'(ID_LEN - 1));
      case (state_q.kind)
         rssr_pkg::TX_IDLE:
         begin
            if (start_i)
            begin
               state_d.kind = kind_i;
               state_d.idx = 4'h0;
               case (kind_i)
                  rssr_pkg::TX_STATUS: state_d.data = status_i;
                  rssr_pkg::TX_ACC: state_d.data = rssr_pkg::ACCESSORY_CLASS;
                  rssr_pkg::TX_ID: state_d.data = id_str_i[8*ID_LEN-1 -: 8];
                  default: state_d.data = 8'h00;
               endcase
            end
         end
         default:
         begin
            if (tx_rdy_i)
            begin
               if (last)
               begin
                  state_d.kind = rssr_pkg::TX_IDLE;
               end
               else
               begin
                  state_d.idx = state_q.idx + 4'h1;
                  state_d.data = id_str_i[8*ID_LEN-1-8*(int'(state_q.idx)+1) -: 8];
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign tx_vld_o = state_q.kind != rssr_pkg::TX_IDLE;
   assign tx_data_o = state_q.data;
   assign tx_last_o = tx_vld_o && last;
endmodule

/* File: rssr_top.sv */
// Remote status byte, service request, polls and controller operations.
// Assumes an interface decoder presenting each message as a one-cycle strobe.
`timescale 1ns/1ps
module rssr_top #(
   // Arbitrary neutral identity string
   parameter logic [8*rssr_pkg::ID_LEN-1:0] ID_STRING = "MODEL01"
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic cmd_vld_i,
   input wire rssr_pkg::rssr_cmd_t cmd_i,
   input wire logic [3:0] cmd_param_i,
   input wire logic ren_line_i,
   input wire logic loop_mode_i,
   input wire logic mask_wr_i,
   input wire logic [3:0] mask_data_i,
   input wire logic trig_report_i,
   input wire logic meas_done_i,
   input wire logic probe_press_i,
   input wire logic err_present_i,
   input wire logic key_clear_local_i,
   input wire logic tx_rdy_i,
   output logic [7:0] status_o,
   output logic srq_o,
   output logic ppoll_en_o,
   output logic [2:0] ppoll_line_o,
   output logic ppoll_bit_o,
   output logic keys_enable_o,
   output logic clear_local_en_o,
   output logic remote_o,
   output logic listener_o,
   output logic talker_o,
   output logic next_triggered_o,
   output logic meas_clear_o,
   output logic err_clear_o,
   output logic tx_vld_o,
   output logic [7:0] tx_data_o,
   output logic tx_last_o
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] mask;
      logic [2:0] cond;
      logic power_on;
      logic trig_rep;
      logic next_trig;
      logic spoll_en;
      logic pp_en;
      logic [2:0] pp_line;
      logic pp_sense;
      logic meas_clr;
      logic err_clr;
   } rssr_top_state_t;

   rssr_top_state_t state_q;
   rssr_top_state_t state_d;
   logic lockout;
   logic local_st;
   logic [3:0] cond_all;
   logic srq_flag;
   logic [7:0] status_byte;
   logic status_read;
   logic tx_start;
   rssr_pkg::rssr_tx_t tx_kind;
   logic is_cmd;

   rssr_remote_fsm u_remote (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .cmd_vld_i(cmd_vld_i),
      .cmd_i(cmd_i),
      .ren_line_i(ren_line_i),
      .remote_o(remote_o),
      .lockout_o(lockout),
      .listener_o(listener_o),
      .talker_o(talker_o)
   );

   assign local_st = !remote_o;
   assign cond_all = {local_st, state_q.cond};
   assign srq_flag = remote_o && |(cond_all & state_q.mask);

   // ------------------------------------------------------------
   // Status byte assembly
   // ------------------------------------------------------------
   always_comb
   begin
      status_byte = 8'h00;
      status_byte[rssr_pkg::BIT_DATA_READY] = state_q.cond[0];
      status_byte[rssr_pkg::BIT_TRIG_OCC] = state_q.cond[1];
      status_byte[rssr_pkg::BIT_ERR_FAIL] = state_q.cond[2];
      status_byte[rssr_pkg::BIT_ZERO3] = 1'b0;
      status_byte[rssr_pkg::BIT_LOCAL] = local_st;
      status_byte[rssr_pkg::BIT_POWER_ON] = state_q.power_on;
      status_byte[rssr_pkg::BIT_SRQ_FLAG] = srq_flag;
      status_byte[rssr_pkg::BIT_ZERO7] = 1'b0;
   end

   assign is_cmd = cmd_vld_i;
   // serial poll via enable or send-status, plus accessory and identity answers
   always_comb
   begin
      tx_start = 1'b0;
      tx_kind = rssr_pkg::TX_IDLE;
      if (is_cmd && talker_o && !tx_vld_o)
      begin
         if (cmd_i == rssr_pkg::CMD_SST && loop_mode_i)
         begin
            tx_start = 1'b1;
            tx_kind = rssr_pkg::TX_STATUS;
         end
         else if (cmd_i == rssr_pkg::CMD_SAI)
         begin
            tx_start = 1'b1;
            tx_kind = rssr_pkg::TX_ACC;
         end
         else if (cmd_i == rssr_pkg::CMD_SDI)
         begin
            tx_start = 1'b1;
            tx_kind = rssr_pkg::TX_ID;
         end
      end
      else if (is_cmd && cmd_i == rssr_pkg::CMD_UNT && state_q.spoll_en && !tx_vld_o)
      begin
         tx_start = 1'b0;
      end
      // Enabled serial poll answers once per MTA-already-held enable
      if (is_cmd && cmd_i == rssr_pkg::CMD_SPE && talker_o && !loop_mode_i && !tx_vld_o)
      begin
         tx_start = 1'b1;
         tx_kind = rssr_pkg::TX_STATUS;
      end
   end
   // any accepted status send counts as a read
   assign status_read = tx_start && tx_kind == rssr_pkg::TX_STATUS;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      state_d.meas_clr = 1'b0;
      state_d.err_clr = 1'b0;
      if (mask_wr_i)
      begin
         state_d.mask = mask_data_i;
      end
      if (trig_report_i)
      begin
         state_d.trig_rep = 1'b1;
      end
      // read clears data ready, trigger and power-on bits
      if (status_read)
      begin
         state_d.cond[1:0] = 2'b00;
         state_d.power_on = 1'b0;
      end
      if (is_cmd)
      begin
         case (cmd_i)
            rssr_pkg::CMD_SPE: state_d.spoll_en = 1'b1;
            rssr_pkg::CMD_SPD: state_d.spoll_en = 1'b0;
            rssr_pkg::CMD_GET: if (listener_o) state_d.next_trig = 1'b1;
            rssr_pkg::CMD_PPE:
            begin
               state_d.pp_en = 1'b1;
               state_d.pp_sense = cmd_param_i[3];
               state_d.pp_line = cmd_param_i[2:0];
            end
            rssr_pkg::CMD_PPU: state_d.pp_en = 1'b0;
            rssr_pkg::CMD_PPD: if (listener_o) state_d.pp_en = 1'b0;
            rssr_pkg::CMD_SDC, rssr_pkg::CMD_DCL:
            begin
               if (listener_o || cmd_i == rssr_pkg::CMD_DCL)
               begin
                  state_d.power_on = 1'b0;
                  if (err_present_i)
                  begin
                     state_d.err_clr = 1'b1;
                  end
                  else
                  begin
                     state_d.meas_clr = 1'b1;
                     state_d.cond[1:0] = 2'b00;
                  end
               end
            end
            rssr_pkg::CMD_SRQ: state_d.spoll_en = state_q.spoll_en;
            default:
            begin
            end
         endcase
      end
      if (meas_done_i)
      begin
         state_d.next_trig = 1'b0;
      end
      if (probe_press_i)
      begin
         state_d.next_trig = 1'b1;
         if (state_q.trig_rep)
         begin
            state_d.cond[1] = 1'b1;
         end
      end
      // data ready, set wins over read
      if (meas_done_i)
      begin
         state_d.cond[0] = 1'b1;
      end
      state_d.cond[2] = err_present_i;
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         state_q <= '0;
         state_q.mask <= rssr_pkg::MASK_RESET;
         state_q.power_on <= 1'b1;
         state_q.pp_line <= rssr_pkg::PPOLL_LINE_RESET;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   rssr_tx_seq #(
      .ID_LEN(rssr_pkg::ID_LEN)
   ) u_tx (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(tx_start),
      .kind_i(tx_kind),
      .status_i(status_byte),
      .id_str_i(ID_STRING),
      .tx_rdy_i(tx_rdy_i),
      .tx_vld_o(tx_vld_o),
      .tx_data_o(tx_data_o),
      .tx_last_o(tx_last_o)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign status_o = status_byte;
   assign srq_o = srq_flag;
   assign ppoll_en_o = state_q.pp_en;
   assign ppoll_line_o = state_q.pp_line;
   assign ppoll_bit_o = state_q.pp_en && (srq_flag == state_q.pp_sense);
   assign keys_enable_o = !remote_o;
   assign clear_local_en_o = !(remote_o && lockout) && key_clear_local_i | 1'b1;
   assign next_triggered_o = state_q.next_trig;
   assign meas_clear_o = state_q.meas_clr;
   assign err_clear_o = state_q.err_clr;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_mask_gates_srq: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      srq_o |-> |(cond_all & state_q.mask))
      else $error("Request raised by masked condition");
   a_status_zeros: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      !status_o[3] && !status_o[7])
      else $error("Reserved status bit set");
   a_data_ready_set: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      meas_done_i |=> status_o[0])
      else $error("Data ready not recorded");
   a_get_marks: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      cmd_vld_i && cmd_i == rssr_pkg::CMD_GET && listener_o && !meas_done_i
      |=> next_triggered_o)
      else $error("Trigger not marked");
   a_poll_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      ppoll_en_o |-> ppoll_bit_o == (srq_o == state_q.pp_sense))
      else $error("Poll bit wrong");
   a_power_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      status_read |=> !status_o[5])
      else $error("Power-on bit held after read");
   a_local_keys: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      keys_enable_o == status_o[4])
      else $error("Key enable disagrees with local bit");
   a_err_follow: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      err_present_i |=> status_o[2])
      else $error("Error bit missing");
endmodule

/* File: rssr_ctrl_model.sv */
// Bus controller model: collects talker bytes and can stall the talker.
// Assumes the block holds its byte until an edge with ready high.
`timescale 1ns/1ps
module rssr_ctrl_model (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic stall_i,
   input wire logic tx_vld_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_rdy_o,
   output logic [63:0] rx_bytes_o,
   output logic [7:0] rx_cnt_o
);
   // ------------------------------------------------------------
   // Byte collection
   // ------------------------------------------------------------
   // reads answer byte
   assign tx_rdy_o = !stall_i;
   // First byte ends up most significant, like a string literal
   always @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         rx_bytes_o <= 64'h0;
         rx_cnt_o <= 8'h00;
      end
      else if (tx_vld_i && tx_rdy_o)
      begin
         rx_bytes_o <= {rx_bytes_o[55:0], tx_data_i};
         rx_cnt_o <= rx_cnt_o + 8'h01;
      end
   end
endmodule

/* File: rssr_top_tb.sv */
// Testbench for the status and service-request block.
// Assumes the design answers one cycle after each command strobe.
`timescale 1ns/1ps
module rssr_top_tb;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cmd_vld_i = 1'b0;
   rssr_pkg::rssr_cmd_t cmd_i = rssr_pkg::CMD_NONE;
   logic [3:0] cmd_param_i = 4'h0;
   logic ren_line_i = 1'b0;
   logic loop_mode_i = 1'b0;
   logic mask_wr_i = 1'b0;
   logic [3:0] mask_data_i = 4'h0;
   logic trig_report_i = 1'b0;
   logic meas_done_i = 1'b0;
   logic probe_press_i = 1'b0;
   logic err_present_i = 1'b0;
   logic stall = 1'b0;
   logic tx_rdy;
   logic [7:0] status_o;
   logic srq_o, ppoll_en_o, ppoll_bit_o, keys_enable_o, clear_local_en_o;
   logic remote_o, listener_o, talker_o, next_triggered_o;
   logic meas_clear_o, err_clear_o, tx_vld, tx_last;
   logic [2:0] ppoll_line_o;
   logic [7:0] tx_data;
   logic [63:0] rx_bytes;
   logic [7:0] rx_cnt;
   logic ec_seen, mc_seen;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;

   always #5 mclk_i = ~mclk_i;

   rssr_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmd_vld_i(cmd_vld_i),
      .cmd_i(cmd_i), .cmd_param_i(cmd_param_i), .ren_line_i(ren_line_i),
      .loop_mode_i(loop_mode_i), .mask_wr_i(mask_wr_i), .mask_data_i(mask_data_i),
      .trig_report_i(trig_report_i), .meas_done_i(meas_done_i),
      .probe_press_i(probe_press_i), .err_present_i(err_present_i),
      .key_clear_local_i(1'b0), .tx_rdy_i(tx_rdy), .status_o(status_o), .srq_o(srq_o),
      .ppoll_en_o(ppoll_en_o), .ppoll_line_o(ppoll_line_o), .ppoll_bit_o(ppoll_bit_o),
      .keys_enable_o(keys_enable_o), .clear_local_en_o(clear_local_en_o),
      .remote_o(remote_o), .listener_o(listener_o), .talker_o(talker_o),
      .next_triggered_o(next_triggered_o), .meas_clear_o(meas_clear_o),
      .err_clear_o(err_clear_o), .tx_vld_o(tx_vld), .tx_data_o(tx_data),
      .tx_last_o(tx_last));

   rssr_ctrl_model ctrl (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .stall_i(stall),
      .tx_vld_i(tx_vld), .tx_data_i(tx_data), .tx_rdy_o(tx_rdy),
      .rx_bytes_o(rx_bytes), .rx_cnt_o(rx_cnt));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %0h expected %0h", $time, g, e);
      end
   endtask

   task automatic cmd(input rssr_pkg::rssr_cmd_t c, input logic [3:0] p);
      @(negedge mclk_i);
      cmd_i = c;
      cmd_param_i = p;
      cmd_vld_i = 1'b1;
      @(negedge mclk_i);
      cmd_vld_i = 1'b0;
      cmd_i = rssr_pkg::CMD_NONE;
   endtask

   // Pulse select: 0 done, 1 trigger report, 2 probe, 3 mask write
   task automatic pulse(input int k);
      @(negedge mclk_i);
      meas_done_i = (k == 0);
      trig_report_i = (k == 1);
      probe_press_i = (k == 2);
      mask_wr_i = (k == 3);
      @(negedge mclk_i);
      {meas_done_i, trig_report_i, probe_press_i, mask_wr_i} = 4'h0;
   endtask

   // Bounded wait, a hang shows up as a count mismatch
   task automatic wait_rx(input logic [7:0] n);
      for (int i = 0; i < 40 && rx_cnt !== n; i++)
         @(negedge mclk_i);
      chk(rx_cnt, n);
   endtask

   always @(posedge mclk_i)
   begin
      cyc++;
      ec_seen = ec_seen | err_clear_o;
      mc_seen = mc_seen | meas_clear_o;
      if (cyc == 3000)
      begin
         error_cnt++;
         final_report();
      end
   end

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (5) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      chk(status_o, 8'h30);
      chk(keys_enable_o, 1'b1);
      pulse(1);
      pulse(2);
      chk(status_o, 8'h32);
      chk(srq_o, 1'b0);
      ren_line_i = 1'b1;
      cmd(rssr_pkg::CMD_REN, 4'h0);
      cmd(rssr_pkg::CMD_MLA, 4'h0);
      chk(remote_o, 1'b1);
      chk(keys_enable_o, 1'b0);
      mask_data_i = 4'h1;
      pulse(3);
      pulse(0);
      chk(status_o, 8'h63);
      chk(srq_o, 1'b1);
      cmd(rssr_pkg::CMD_PPE, 4'h9);
      chk({ppoll_en_o, ppoll_line_o, ppoll_bit_o}, 5'h13);
      cmd(rssr_pkg::CMD_MTA, 4'h0);
      cmd(rssr_pkg::CMD_SPE, 4'h0);
      wait_rx(8'h01);
      chk(rx_bytes[7:0], 8'h63);
      repeat (2) @(negedge mclk_i);
      chk(status_o, 8'h00);
      chk(ppoll_bit_o, 1'b0);
      cmd(rssr_pkg::CMD_SPD, 4'h0);
      cmd(rssr_pkg::CMD_PPU, 4'h0);
      chk(ppoll_en_o, 1'b0);
      cmd(rssr_pkg::CMD_SRQ, 4'h0);
      chk(srq_o, 1'b0);
      cmd(rssr_pkg::CMD_GET, 4'h0);
      chk(next_triggered_o, 1'b1);
      loop_mode_i = 1'b1;
      cmd(rssr_pkg::CMD_SST, 4'h0);
      wait_rx(8'h02);
      chk(rx_bytes[7:0], 8'h00);
      cmd(rssr_pkg::CMD_SAI, 4'h0);
      wait_rx(8'h03);
      chk(rx_bytes[7:0], rssr_pkg::ACCESSORY_CLASS);
      stall = 1'b1;
      cmd(rssr_pkg::CMD_SDI, 4'h0);
      repeat (4) @(negedge mclk_i);
      chk(rx_cnt, 8'h03);
      chk({tx_vld, tx_last, tx_data}, {2'b10, 8'h4d});
      stall = 1'b0;
      wait_rx(8'h0a);
      chk(rx_bytes[55:0], "MODEL01");
      err_present_i = 1'b1;
      @(negedge mclk_i);
      chk(status_o, 8'h04);
      {ec_seen, mc_seen} = 2'b00;
      cmd(rssr_pkg::CMD_SDC, 4'h0);
      repeat (2) @(negedge mclk_i);
      chk({ec_seen, mc_seen}, 2'b10);
      err_present_i = 1'b0;
      {ec_seen, mc_seen} = 2'b00;
      cmd(rssr_pkg::CMD_DCL, 4'h0);
      repeat (2) @(negedge mclk_i);
      chk({ec_seen, mc_seen}, 2'b01);
      cmd(rssr_pkg::CMD_LLO, 4'h0);
      chk(clear_local_en_o, 1'b0);
      cmd(rssr_pkg::CMD_GTL, 4'h0);
      chk({remote_o, keys_enable_o}, 2'b01);
      chk(status_o, 8'h10);
      cmd(rssr_pkg::CMD_IFC, 4'h0);
      chk({talker_o, listener_o}, 2'b00);
      final_report();
   end
endmodule
